// [rtl/simd_state_save_control_check.sv]
/*
  Vector-unit architectural state: control/status register with
  reserved-bit check, 512-byte save and restore image, register storage.
  Assumes an Avalon-MM master with waitrequest and one 10 MHz clock.
*/
// Function
// - Full-word control/status write with reserved bit set faults instead of completing
// - Save stores fp, packed, eight vector regs and control word in 512 bytes
// - Restore reloads vector regs, control/status and fp state from image
// - Packed-integer registers share storage with fp data registers
// - Supported-bits mask goes to image bytes 28 to 31; zero allowed
// - Zero mask field means default mask 0000FFBF, bit 6 reserved
// - Each zero mask bit is reserved; writing one faults
// - Each one mask bit is an implemented feature flag
// - Vector register loads do no data type checking
// - Mismatched type arithmetic never raises undefined-opcode fault
// - Vector floating point stays in native precision
// - Vector-only ops interleave freely with fp and packed ops
// - Storing vector registers costs no type-mismatch latency
// - Reset loads 1F80 and clears vector regs; init leaves them
`timescale 1ns/1ns
`default_nettype none
`include "simd_state_defines.svh"

module simd_state_save_control_check #(
  parameter bit DAZ_SUPPORTED = 1'b0,
  parameter bit MASK_FIELD_ZERO = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic general_protection_fault,
  output logic busy
);

  import simd_state_pkg::*;

  regs_t q;
  regs_t d;
  logic [31:0] img_rdata;
  logic [31:0] st_rdata;
  logic [31:0] img_wdata;
  logic [31:0] st_wdata;
  logic [31:0] chk_value;
  logic [31:0] mask;
  logic [31:0] field_mask;
  logic [6:0] img_addr;
  logic [5:0] st_addr;
  logic [6:0] st_off;
  logic img_we;
  logic st_we;
  logic chk_fault;
  logic take_wr;

  //////////////////////////////////////////////////////////////////////
  // Image area holding register storage
  function automatic logic in_st_area(input logic [6:0] idx);
    in_st_area = (idx >= `IMG_ST_FIRST) && (idx <= `IMG_ST_LAST);
  endfunction

  // Last word of an image walk
  function automatic logic last_img_word(input logic [6:0] idx);
    last_img_word = (idx == `IMG_LAST);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Memories and checker

  state_mem #(
    .WIDTH(32),
    .DEPTH(`ST_WORDS)
  ) u_regs (
    .clk(clk),
    .we(st_we),
    .addr(st_addr),
    .wdata(st_wdata),
    .rdata(st_rdata)
  );

  state_mem #(
    .WIDTH(32),
    .DEPTH(`IMG_WORDS)
  ) u_image (
    .clk(clk),
    .we(img_we),
    .addr(img_addr),
    .wdata(img_wdata),
    .rdata(img_rdata)
  );

  csr_check u_check (
    .value(chk_value),
    .daz_supported(DAZ_SUPPORTED),
    .mask(mask),
    .fault(chk_fault)
  );

  //////////////////////////////////////////////////////////////////////
  // Bus handshake
  assign busy = (q.state != ST_IDLE);
  assign waitrequest = busy | (read & (q.rd_cnt != 2'd2));
  assign take_wr = write & ~busy & (byteenable == 4'hF);
  assign readdata = q.rdata;
  assign st_off = q.idx - `IMG_ST_FIRST;

  assign field_mask = MASK_FIELD_ZERO ? 32'h0000_0000 : mask;

  //////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    img_we = 1'b0;
    st_we = 1'b0;
    img_addr = q.img_addr;
    st_addr = q.st_addr;
    img_wdata = writedata;
    st_wdata = writedata;
    chk_value = writedata;
    general_protection_fault = 1'b0;
    case (q.state)
      ST_CLEAR: begin
        st_we = 1'b1;
        st_addr = q.idx[5:0];
        st_wdata = 32'h0000_0000;
        d.idx = q.idx + 7'd1;
        if (q.idx == `ST_LAST) begin
          d.idx = 7'h00;
          d.state = ST_IDLE;
        end
      end
      ST_SAVE_RD: begin
        st_addr = st_off[5:0];
        d.state = ST_SAVE_WR;
      end
      ST_SAVE_WR: begin
        img_we = 1'b1;
        img_addr = q.idx;
        case (q.idx)
          `IMG_W_FPCTL: begin
            img_wdata = {q.fsw, q.fcw};
          end
          `IMG_W_TAGS: begin
            img_wdata = {24'h000000, q.ftw};
          end
          `IMG_W_CSR: begin
            img_wdata = q.csr;
          end
          `IMG_W_MASK: begin
            img_wdata = field_mask;
          end
          default: begin
            if (in_st_area(q.idx)) begin
              img_wdata = st_rdata;
            end else begin
              img_wdata = 32'h0000_0000;
            end
          end
        endcase
        d.idx = q.idx + 7'd1;
        d.state = ST_SAVE_RD;
        if (last_img_word(q.idx)) begin
          d.idx = 7'h00;
          d.state = ST_IDLE;
        end
      end
      ST_RST_RD: begin
        img_addr = q.idx;
        d.state = ST_RST_WR;
      end
      ST_RST_WR: begin
        chk_value = img_rdata;
        st_wdata = img_rdata;
        case (q.idx)
          `IMG_W_FPCTL: begin
            d.fcw = img_rdata[15:0];
            d.fsw = img_rdata[31:16];
          end
          `IMG_W_TAGS: begin
            d.ftw = img_rdata[7:0];
          end
          `IMG_W_CSR: begin
            if (chk_fault) begin
              d.fault = 1'b1;
              general_protection_fault = 1'b1;
            end else begin
              d.csr = img_rdata;
            end
          end
          default: begin
            if (in_st_area(q.idx)) begin
              st_we = 1'b1;
              st_addr = st_off[5:0];
            end
          end
        endcase
        d.idx = q.idx + 7'd1;
        d.state = ST_RST_RD;
        if (last_img_word(q.idx)) begin
          d.idx = 7'h00;
          d.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take_wr) begin
          case (address)
            `OFS_CMD: begin
              if (writedata[`CMD_SAVE]) begin
                d.state = ST_SAVE_RD;
              end else if (writedata[`CMD_RESTORE]) begin
                d.state = ST_RST_RD;
              end
              if (writedata[`CMD_EMPTY]) begin
                d.ftw = 8'h00;
              end
              d.idx = 7'h00;
            end
            `OFS_STATUS: begin
              if (writedata[`STS_FAULT]) begin
                d.fault = 1'b0;
              end
            end
            `OFS_CSR: begin
              if (chk_fault) begin
                d.fault = 1'b1;
                general_protection_fault = 1'b1;
              end else begin
                d.csr = writedata;
              end
            end
            `OFS_FPCTL: begin
              d.fcw = writedata[15:0];
              d.fsw = writedata[31:16];
            end
            `OFS_IMG_ADDR: begin
              d.img_addr = writedata[6:0];
            end
            `OFS_IMG_DATA: begin
              img_we = 1'b1;
            end
            `OFS_ST_ADDR: begin
              d.st_addr = writedata[5:0];
            end
            `OFS_ST_DATA: begin
              st_we = 1'b1;
            end
            default: begin
              d.idx = q.idx;
            end
          endcase
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase

    // Read pipeline: address, memory, data register
    if (read && !busy) begin
      d.rd_cnt = (q.rd_cnt == 2'd2) ? 2'd0 : q.rd_cnt + 2'd1;
    end
    if (q.rd_cnt == 2'd1) begin
      case (address)
        `OFS_STATUS: begin
          d.rdata = 32'h0000_0000;
          d.rdata[`STS_BUSY] = busy;
          d.rdata[`STS_FAULT] = q.fault;
          d.rdata[`STS_DAZ] = DAZ_SUPPORTED;
        end
        `OFS_CSR: begin
          d.rdata = q.csr;
        end
        `OFS_MASK: begin
          d.rdata = mask;
        end
        `OFS_FPCTL: begin
          d.rdata = {q.fsw, q.fcw};
        end
        `OFS_IMG_ADDR: begin
          d.rdata = {25'h0000000, q.img_addr};
        end
        `OFS_IMG_DATA: begin
          d.rdata = img_rdata;
        end
        `OFS_ST_ADDR: begin
          d.rdata = {26'h0000000, q.st_addr};
        end
        `OFS_ST_DATA: begin
          d.rdata = st_rdata;
        end
        `OFS_TAGS: begin
          d.rdata = {24'h000000, q.ftw};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Fault set wins over a clear in the same cycle
    if (general_protection_fault) begin
      d.fault = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{state: ST_CLEAR, csr: `CSR_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// [rtl/simd_state_defines.svh]
/*
  Offsets, field positions, reset values and image layout for the
  vector-unit state block. Assumes 32-bit Avalon-MM byte addressing.
*/
`ifndef SIMD_STATE_DEFINES_SVH
`define SIMD_STATE_DEFINES_SVH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CSR 8'h08
`define OFS_MASK 8'h0C
`define OFS_FPCTL 8'h10
`define OFS_IMG_ADDR 8'h14
`define OFS_IMG_DATA 8'h18
`define OFS_ST_ADDR 8'h1C
`define OFS_ST_DATA 8'h20
`define OFS_TAGS 8'h24

// Command bits
`define CMD_SAVE 0
`define CMD_RESTORE 1
`define CMD_INIT 2
`define CMD_EMPTY 3

// Status bits
`define STS_BUSY 0
`define STS_FAULT 1
`define STS_DAZ 2

// Control/status values
`define CSR_RESET 32'h0000_1F80
`define MASK_DEFAULT 32'h0000_FFBF
`define MASK_FULL 32'h0000_FFFF

// Save image layout, in 32-bit words of the 512-byte image
`define IMG_WORDS 128
`define IMG_LAST 7'h7F
`define IMG_W_FPCTL 7'h00
`define IMG_W_TAGS 7'h01
`define IMG_W_CSR 7'h06
`define IMG_W_MASK 7'h07
`define IMG_ST_FIRST 7'h08
`define IMG_ST_LAST 7'h47

// Register storage: fp/packed regs words 0..31, vector regs 32..63
`define ST_WORDS 64
`define ST_LAST 7'h3F

`endif

// [rtl/simd_state_pkg.sv]
/*
  Types for the vector-unit state block.
  Assumes simd_state_defines.svh is on the include path.
*/
package simd_state_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_SAVE_RD = 3'b010,
    ST_SAVE_WR = 3'b011,
    ST_RST_RD = 3'b100,
    ST_RST_WR = 3'b101
  } state_t;

  typedef struct packed {
    state_t state;
    logic [6:0] idx;
    logic [31:0] csr;
    logic fault;
    logic [15:0] fcw;
    logic [15:0] fsw;
    logic [7:0] ftw;
    logic [6:0] img_addr;
    logic [5:0] st_addr;
    logic [1:0] rd_cnt;
    logic [31:0] rdata;
  } regs_t;

endpackage

// [rtl/state_mem.sv]
/*
  Single-port word memory with registered read data.
  Assumes one clock; no reset on contents.
*/
`timescale 1ns/1ns
`default_nettype none

module state_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// [rtl/csr_check.sv]
/*
  Supported-bits mask and reserved-bit check for the control/status value.
  Assumes a static capability input.
*/
`timescale 1ns/1ns
`default_nettype none
`include "simd_state_defines.svh"

module csr_check (
  input wire logic [31:0] value,
  input wire logic daz_supported,
  output logic [31:0] mask,
  output logic fault
);

  // Capability mask
  assign mask = daz_supported ? `MASK_FULL : `MASK_DEFAULT;

  assign fault = |(value & ~mask);

endmodule

`default_nettype wire

// [verification/simd_state_checker.sv]
/*
  Port checker for the vector state block.
  Assumes bind onto the top module and the defines header on the path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "simd_state_defines.svh"

module simd_state_checker #(
  parameter bit DAZ_SUPPORTED = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic general_protection_fault,
  input wire logic busy
);
  localparam logic [31:0] MASK = DAZ_SUPPORTED ? `MASK_FULL : `MASK_DEFAULT;
  logic csr_wr;
  logic bad;
  logic save_wr;
  int unsigned span;
  assign csr_wr = write && !waitrequest && address == `OFS_CSR && byteenable == 4'hF;
  assign bad = (writedata & ~MASK) != 32'h0000_0000;
  assign save_wr = write && !waitrequest && address == `OFS_CMD && writedata[0];

  // Length of the current busy stretch
  always_ff @(posedge clk) begin
    if (sys_rst || !busy) begin
      span <= 32'h0;
    end else begin
      span <= span + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  a_busy_holds_bus: assert property (busy |-> waitrequest)
    else $error("bus not held while busy");
  a_write_no_wait: assert property (write && !busy |-> !waitrequest)
    else $error("idle write waited");
  a_read_two_waits: assert property ($rose(read) && !busy |->
    waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("idle read wait count wrong");
  a_bad_csr_faults: assert property (csr_wr && bad |-> general_protection_fault)
    else $error("reserved bit write did not fault");
  a_fault_has_cause: assert property (general_protection_fault && !busy |-> csr_wr && bad)
    else $error("fault without reserved bit write");
  a_mask_read: assert property (read && !waitrequest && address == `OFS_MASK |->
    readdata == MASK)
    else $error("mask read wrong");
  a_reset_clear: assert property ($fell(sys_rst) |-> busy [*8])
    else $error("no clear walk after reset");
  a_save_length: assert property (save_wr |=> busy [*8] ##[230:260] !busy)
    else $error("save duration wrong");
  a_busy_span: assert property ($fell(busy) |-> span == 32'h40 || span == 32'h100)
    else $error("busy stretch length wrong");

  c_save: cover property (save_wr);
  c_restore_fault: cover property (busy && general_protection_fault);
  c_csr_fault: cover property (csr_wr && bad);
endmodule

bind simd_state_save_control_check simd_state_checker #(
  .DAZ_SUPPORTED(DAZ_SUPPORTED)
) simd_state_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .general_protection_fault(general_protection_fault),
  .busy(busy)
);
`default_nettype wire

// [verification/simd_state_save_control_check_tb_top.sv]
/*
  Register-level testbench for the vector state block.
  Assumes the design, checker and defines header are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "simd_state_defines.svh"
`define CHK(got, want) begin tests_run++; if ((got) !== (want)) begin err_total++; \
  $display("mismatch t=%0t got=%h want=%h", $time, got, want); end end

module simd_state_save_control_check_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic general_protection_fault;
  logic busy;
  logic [31:0] v;
  logic f;
  int err_total = 0;
  int tests_run = 0;
  logic [6:0] ii [7] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h08, 7'h28, 7'h64};
  logic [31:0] ie [7] = '{32'h00AB_037F, 32'h0, 32'h0000_FFBF, 32'h0, 32'h11, 32'h22, 32'h0};

  simd_state_save_control_check simd_state_save_control_check_inst (
    .clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .general_protection_fault(general_protection_fault),
    .busy(busy)
  );

  initial begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 2000) begin
      err_total++;
      results();
    end
    v = readdata;
    f = general_protection_fault;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    xfer(a, 32'h0, 1'b0);
    `CHK(v, want)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`OFS_CSR, `CSR_RESET);
    rd_chk(`OFS_MASK, `MASK_DEFAULT);
    rd_chk(`OFS_STATUS, 32'h0);
    xfer(`OFS_CSR, 32'h0000_0040, 1'b1);
    `CHK(f, 1'b1)
    byteenable <= 4'h3;
    xfer(`OFS_CSR, 32'h0000_0040, 1'b1);
    `CHK(f, 1'b0)
    byteenable <= 4'hF;
    rd_chk(`OFS_CSR, `CSR_RESET);
    xfer(`OFS_CSR, 32'h0001_0000, 1'b1);
    `CHK(f, 1'b1)
    rd_chk(`OFS_STATUS, 32'h2);
    xfer(`OFS_STATUS, 32'h2, 1'b1);
    rd_chk(`OFS_STATUS, 32'h0);
    xfer(`OFS_CSR, `MASK_DEFAULT, 1'b1);
    `CHK(f, 1'b0)
    rd_chk(`OFS_CSR, `MASK_DEFAULT);
    xfer(`OFS_CMD, 32'h4, 1'b1);
    rd_chk(`OFS_CSR, `MASK_DEFAULT);
    // Fill one fp word, one vector word and fp control
    xfer(`OFS_ST_ADDR, 32'h0, 1'b1);
    xfer(`OFS_ST_DATA, 32'h11, 1'b1);
    xfer(`OFS_ST_ADDR, 32'h20, 1'b1);
    xfer(`OFS_ST_DATA, 32'h22, 1'b1);
    xfer(`OFS_FPCTL, 32'h00AB_037F, 1'b1);
    xfer(`OFS_CMD, 32'h1, 1'b1);
    for (int i = 0; i < 7; i++) begin
      xfer(`OFS_IMG_ADDR, {25'h0, ii[i]}, 1'b1);
      rd_chk(`OFS_IMG_DATA, ie[i]);
    end
    // Disturb state, then restore it
    xfer(`OFS_ST_ADDR, 32'h0, 1'b1);
    xfer(`OFS_ST_DATA, 32'h33, 1'b1);
    xfer(`OFS_FPCTL, 32'h0, 1'b1);
    xfer(`OFS_CSR, `CSR_RESET, 1'b1);
    xfer(`OFS_CMD, 32'h2, 1'b1);
    rd_chk(`OFS_ST_DATA, 32'h11);
    rd_chk(`OFS_CSR, `MASK_DEFAULT);
    rd_chk(`OFS_FPCTL, 32'h00AB_037F);
    // Restore of an image with a reserved control bit and a tag byte
    xfer(`OFS_IMG_ADDR, 32'h1, 1'b1);
    xfer(`OFS_IMG_DATA, 32'h0000_005A, 1'b1);
    xfer(`OFS_IMG_ADDR, 32'h6, 1'b1);
    xfer(`OFS_IMG_DATA, 32'h0000_1FC0, 1'b1);
    xfer(`OFS_CSR, `CSR_RESET, 1'b1);
    xfer(`OFS_CMD, 32'h2, 1'b1);
    rd_chk(`OFS_CSR, `CSR_RESET);
    rd_chk(`OFS_STATUS, 32'h2);
    rd_chk(`OFS_TAGS, 32'h0000_005A);
    xfer(`OFS_CMD, 32'h8, 1'b1);
    rd_chk(`OFS_TAGS, 32'h0);
    rd_chk(8'hF0, 32'h0);
    // Mid-run reset clears storage and sticky fault, reloads control word to 1F80
    xfer(`OFS_CSR, `MASK_DEFAULT, 1'b1);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk(`OFS_STATUS, 32'h0);
    rd_chk(`OFS_CSR, `CSR_RESET);
    xfer(`OFS_ST_ADDR, 32'h20, 1'b1);
    rd_chk(`OFS_ST_DATA, 32'h0);
    results();
  end
endmodule
`default_nettype wire
